// ===== hdl/card_id_op_cond_regs.sv
`include "card_id_regs.svh"
`default_nettype none
module card_id_op_cond_regs
  import card_id_pkg::*;
#(
  parameter bit DUAL_VOLTAGE = 1'b1,
  parameter bit SECTOR_MODE = 1'b1,
  // value arbitrary
  parameter logic [7:0] MAKER_CODE = 8'h5a,
  parameter card_id_pkg::package_type_t PACKAGE_TYPE = card_id_pkg::PKG_BGA,
  // value arbitrary
  parameter logic [7:0] OEM_CODE = 8'h3c,
  parameter logic [47:0] PRODUCT_NAME = 48'h41_42_43_44_45_46,
  parameter logic [7:0] PRODUCT_REVISION = 8'h10,
  parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001,
  parameter logic [7:0] MANUFACTURE_DATE = 8'h10
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic power_up_done,
  input wire logic cmd_valid,
  input wire card_id_pkg::reg_sel_t cmd_sel,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [127:0] rsp_data,
  output logic id_ready,
  input wire logic ready_line_i,
  output logic ready_line_o,
  output logic ready_line_oe,
  output logic bus_all_ready
);
  import card_id_pkg::*;

  // ----------------------------------------
  // internal state
  // ----------------------------------------
  pwr_state_t state;
  pwr_state_t next_state;
  logic crc_start;
  logic [31:0] op_word;
  logic [127:0] id_body;
  logic [127:0] id_word;
  logic [6:0] id_crc;
  logic [1:0] access_mode;
  logic low_volt_bit;

  crc7_if #(.DATA_W(`IDN_CRC_SPAN)) crc_bus ();

  // ----------------------------------------
  // checksum over the static identity fields
  // ----------------------------------------
  crc7_engine #(.DATA_W(`IDN_CRC_SPAN)) u_crc (
    .ref_clk(ref_clk),
    .rst(rst),
    .crc(crc_bus)
  );

  // one start pulse right after reset release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      crc_start <= 1'b1;
    end else begin
      crc_start <= 1'b0;
    end
  end

  // crc is taken over bits 127:8 only, never over itself
  assign crc_bus.start = crc_start;
  assign crc_bus.data = id_body[`IDN_MAKER_HI:`IDN_DATE_LO];

  // ----------------------------------------
  // identity word assembly
  // ----------------------------------------
  // fields come from parameters so each part can carry its own numbers
  always_comb begin
    id_body = `IDN_RESET;
    id_body[`IDN_MAKER_HI:`IDN_MAKER_LO] = MAKER_CODE;
    id_body[`IDN_RSVD_HI:`IDN_RSVD_LO] = `IDN_RSVD_VALUE;
    id_body[`IDN_PKG_HI:`IDN_PKG_LO] = PACKAGE_TYPE;
    id_body[`IDN_OEM_HI:`IDN_OEM_LO] = OEM_CODE;
    id_body[`IDN_NAME_HI:`IDN_NAME_LO] = PRODUCT_NAME;
    id_body[`IDN_REV_HI:`IDN_REV_LO] = PRODUCT_REVISION;
    id_body[`IDN_SERIAL_HI:`IDN_SERIAL_LO] = SERIAL_NUMBER;
    id_body[`IDN_DATE_HI:`IDN_DATE_LO] = MANUFACTURE_DATE;
    id_body[`IDN_STOP_BIT] = `IDN_STOP_VALUE;
  end

  assign id_crc = crc_bus.value;

  always_comb begin
    id_word = id_body;
    id_word[`IDN_CRC_HI:`IDN_CRC_LO] = id_crc;
  end

  // ----------------------------------------
  // operating conditions word
  // ----------------------------------------
  // access mode code
  assign access_mode = SECTOR_MODE ? `OPC_ACCESS_SECTOR : `OPC_ACCESS_BYTE;
  assign low_volt_bit = DUAL_VOLTAGE;

  always_comb begin
    op_word = `OPC_RESET;
    op_word[`OPC_VOLT_LOW_BIT] = low_volt_bit;
    op_word[`OPC_VOLT_HIGH_HI:`OPC_VOLT_HIGH_LO] = `OPC_VOLT_HIGH_ONES;
    op_word[`OPC_ACCESS_HI:`OPC_ACCESS_LO] = access_mode;
    op_word[`OPC_READY_BIT] = (state == ST_READY);
  end

  // ----------------------------------------
  // power-up sequence
  // ----------------------------------------
  // ready needs both the checksum and the outside power-up signal,
  // otherwise a host could read a half-built identity
  always_comb begin
    next_state = state;
    case (state)
      ST_CRC: begin
        if (crc_bus.done) begin
          next_state = ST_WAIT_PWR;
        end
      end
      ST_WAIT_PWR: begin
        if (power_up_done) begin
          next_state = ST_READY;
        end
      end
      ST_READY: begin
        next_state = ST_READY;
      end
      default: begin
        next_state = ST_CRC;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_CRC;
    end else begin
      state <= next_state;
    end
  end

  // identity valid flag, visible to local control logic only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      id_ready <= 1'b0;
    end else begin
      id_ready <= (next_state != ST_CRC);
    end
  end

  // ----------------------------------------
  // shared ready line
  // ----------------------------------------
  // pull low while busy
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ready_line_o <= 1'b0;
      ready_line_oe <= 1'b1;
      bus_all_ready <= 1'b0;
    end else begin
      ready_line_o <= 1'b0;
      ready_line_oe <= (next_state != ST_READY);
      bus_all_ready <= ready_line_i;
    end
  end

  // ----------------------------------------
  // read command answers
  // ----------------------------------------
  // command only access
  // identity per device
  // identity reads before the checksum is done are refused, not faked
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      rsp_data <= '0;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_error <= 1'b0;
      if (cmd_valid) begin
        case (cmd_sel)
          SEL_OP_COND: begin
            rsp_data <= {96'h0, op_word};
          end
          SEL_IDENTITY: begin
            if (state == ST_CRC) begin
              rsp_data <= '0;
              rsp_error <= 1'b1;
            end else begin
              rsp_data <= id_word;
            end
          end
          default: begin
            rsp_data <= '0;
            rsp_error <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== inc/card_id_regs.svh
`ifndef CARD_ID_REGS_SVH
`define CARD_ID_REGS_SVH
// ----------------------------------------
// operating conditions word layout
// ----------------------------------------
`define OPC_WIDTH 32
`define OPC_READY_BIT 31
`define OPC_ACCESS_HI 30
`define OPC_ACCESS_LO 29
`define OPC_ACCESS_BYTE 2'h0
`define OPC_ACCESS_SECTOR 2'h2
`define OPC_VOLT_LOW_BIT 7
`define OPC_VOLT_HIGH_HI 23
`define OPC_VOLT_HIGH_LO 15
`define OPC_VOLT_HIGH_ONES 9'h1ff
`define OPC_RESET 32'h0000_0000
// ----------------------------------------
// identity word layout
// ----------------------------------------
`define IDN_WIDTH 128
`define IDN_MAKER_HI 127
`define IDN_MAKER_LO 120
`define IDN_RSVD_HI 119
`define IDN_RSVD_LO 114
`define IDN_RSVD_VALUE 6'h00
`define IDN_PKG_HI 113
`define IDN_PKG_LO 112
`define IDN_OEM_HI 111
`define IDN_OEM_LO 104
`define IDN_NAME_HI 103
`define IDN_NAME_LO 56
`define IDN_REV_HI 55
`define IDN_REV_LO 48
`define IDN_SERIAL_HI 47
`define IDN_SERIAL_LO 16
`define IDN_DATE_HI 15
`define IDN_DATE_LO 8
`define IDN_CRC_HI 7
`define IDN_CRC_LO 1
`define IDN_STOP_BIT 0
`define IDN_STOP_VALUE 1'h1
`define IDN_CRC_SPAN 120
`define IDN_RESET 128'h0
// ----------------------------------------
// checksum
// ----------------------------------------
`define CRC7_POLY 7'h09
`define CRC7_RESET 7'h00
`endif

// ===== inc/card_id_pkg.sv
`default_nettype none
package card_id_pkg;
  // register selector carried by a read command
  typedef enum logic [1:0] {
    SEL_OP_COND = 2'b00,
    SEL_IDENTITY = 2'b01
  } reg_sel_t;
  // power-up sequence
  typedef enum logic [1:0] {
    ST_CRC = 2'b00,
    ST_WAIT_PWR = 2'b01,
    ST_READY = 2'b10
  } pwr_state_t;
  // package type codes of the identity word
  typedef enum logic [1:0] {
    PKG_REMOVABLE = 2'b00,
    PKG_BGA = 2'b01,
    PKG_POP = 2'b10,
    PKG_RESERVED = 2'b11
  } package_type_t;
endpackage
`default_nettype wire

// ===== inc/crc7_if.sv
`default_nettype none
interface crc7_if #(parameter int unsigned DATA_W = 120);
  logic start;
  logic [DATA_W-1:0] data;
  logic [6:0] value;
  logic done;
  modport ctl (output start, output data, input value, input done);
  modport eng (input start, input data, output value, output done);
endinterface
`default_nettype wire

// ===== hdl/crc7_engine.sv
`include "card_id_regs.svh"
`default_nettype none
module crc7_engine #(
  parameter int unsigned DATA_W = 120
) (
  input wire logic ref_clk,
  input wire logic rst,
  crc7_if.eng crc
);
  localparam int unsigned CW = $clog2(DATA_W + 1);
  localparam logic [CW-1:0] LAST = CW'(DATA_W - 1);
  logic [DATA_W-1:0] shreg;
  logic [CW-1:0] cnt;
  logic [6:0] acc;
  logic busy;
  logic done_q;
  logic fb;

  // feedback term, msb of the word enters first
  assign fb = shreg[DATA_W-1] ^ acc[6];
  assign crc.value = acc;
  assign crc.done = done_q;

  // one bit per cycle: slow, but the word is static after reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shreg <= '0;
      cnt <= '0;
      acc <= `CRC7_RESET;
      busy <= 1'b0;
      done_q <= 1'b0;
    end else if (crc.start) begin
      shreg <= crc.data;
      cnt <= LAST;
      acc <= `CRC7_RESET;
      busy <= 1'b1;
      done_q <= 1'b0;
    end else if (busy) begin
      acc <= {acc[5:0], 1'b0} ^ (fb ? `CRC7_POLY : 7'h00);
      shreg <= {shreg[DATA_W-2:0], 1'b0};
      if (cnt == '0) begin
        busy <= 1'b0;
        done_q <= 1'b1;
      end else begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/card_id_op_cond_regs_monitor.sv
`default_nettype none
module card_id_op_cond_regs_monitor
  import card_id_pkg::*;
#(
  parameter bit DUAL_VOLTAGE = 1'b1,
  parameter bit SECTOR_MODE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire card_id_pkg::reg_sel_t cmd_sel,
  input wire logic rsp_valid,
  input wire logic rsp_error,
  input wire logic [127:0] rsp_data,
  input wire logic id_ready,
  input wire logic ready_line_i,
  input wire logic ready_line_o,
  input wire logic ready_line_oe,
  input wire logic bus_all_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // good answers to each selector
  sequence op_read_s;
    cmd_valid && cmd_sel == SEL_OP_COND ##1 rsp_valid && !rsp_error;
  endsequence
  sequence id_read_s;
    cmd_valid && cmd_sel == SEL_IDENTITY ##1 rsp_valid && !rsp_error;
  endsequence
  chk_answer_next: assert property (cmd_valid |=> rsp_valid)
    else $error("no answer");
  chk_no_spurious: assert property (!cmd_valid |=> !rsp_valid)
    else $error("spurious answer");
  chk_bad_sel: assert property (cmd_valid && cmd_sel[1] |=> rsp_error)
    else $error("bad selector accepted");
  chk_err_zero: assert property (rsp_error |-> rsp_valid && rsp_data == '0)
    else $error("error answer not clean");
  chk_op_layout: assert property (op_read_s |-> rsp_data[30:0] ==
    {SECTOR_MODE, 1'b0, 5'h00, 9'h1ff, 7'h00, DUAL_VOLTAGE, 7'h00})
    else $error("op word layout");
  chk_op_width: assert property (op_read_s |-> rsp_data[127:32] == '0)
    else $error("op word too wide");
  chk_busy_bit: assert property (op_read_s ##0 !id_ready |-> !rsp_data[31])
    else $error("ready bit early");
  chk_ready_bit: assert property (cmd_valid && cmd_sel == SEL_OP_COND &&
    !ready_line_oe ##1 rsp_valid |-> rsp_data[31])
    else $error("ready bit missing");
  chk_busy_pull: assert property (!id_ready |-> ready_line_oe && !ready_line_o)
    else $error("busy not pulling line");
  chk_line_follow: assert property (!$past(rst) |-> bus_all_ready == $past(ready_line_i))
    else $error("line not followed");
  chk_id_frame: assert property (id_read_s |-> rsp_data[0] && rsp_data[119:114] == 6'h00)
    else $error("identity frame bits");
endmodule
bind card_id_op_cond_regs card_id_op_cond_regs_monitor #(
  .DUAL_VOLTAGE(DUAL_VOLTAGE),
  .SECTOR_MODE(SECTOR_MODE)
) mon (
  .ref_clk(ref_clk),
  .rst(rst),
  .cmd_valid(cmd_valid),
  .cmd_sel(cmd_sel),
  .rsp_valid(rsp_valid),
  .rsp_error(rsp_error),
  .rsp_data(rsp_data),
  .id_ready(id_ready),
  .ready_line_i(ready_line_i),
  .ready_line_o(ready_line_o),
  .ready_line_oe(ready_line_oe),
  .bus_all_ready(bus_all_ready)
);
`default_nettype wire

// ===== tb/ready_line_model.sv
`default_nettype none
module ready_line_model (
  input wire logic dev_oe,
  input wire logic dev_o,
  input wire logic other_busy,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-up wins unless a busy party pulls low
  // wired-and line
  assign line = !((dev_oe && !dev_o) || other_busy);
endmodule
`default_nettype wire

// ===== tb/test_card_id_op_cond_regs.sv
`default_nettype none
module test_card_id_op_cond_regs;
  import card_id_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic power_up_done = 1'b0;
  logic cmd_valid = 1'b0;
  reg_sel_t cmd_sel = SEL_OP_COND;
  logic other_busy = 1'b0;
  logic rsp_valid, rsp_error, id_ready, line_o, line_oe, bus_all_ready, line;
  logic [127:0] rsp_data;
  logic [127:0] rsp_data_b;
  logic [119:0] id_hi;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #20 ref_clk = ~ref_clk;
  card_id_op_cond_regs uut (
    .ref_clk(ref_clk), .rst(rst), .power_up_done(power_up_done),
    .cmd_valid(cmd_valid), .cmd_sel(cmd_sel), .rsp_valid(rsp_valid),
    .rsp_error(rsp_error), .rsp_data(rsp_data), .id_ready(id_ready),
    .ready_line_i(line), .ready_line_o(line_o), .ready_line_oe(line_oe),
    .bus_all_ready(bus_all_ready)
  );
  // second device in byte mode, high voltage only, so both codings get read
  card_id_op_cond_regs #(.DUAL_VOLTAGE(1'b0), .SECTOR_MODE(1'b0)) uut_byte (
    .ref_clk(ref_clk), .rst(rst), .power_up_done(power_up_done),
    .cmd_valid(cmd_valid), .cmd_sel(cmd_sel), .rsp_valid(),
    .rsp_error(), .rsp_data(rsp_data_b), .id_ready(),
    .ready_line_i(line), .ready_line_o(), .ready_line_oe(),
    .bus_all_ready()
  );
  ready_line_model far (.dev_oe(line_oe), .dev_o(line_o), .other_busy(other_busy), .line(line));
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one read, answer looked at in its single valid cycle
  task automatic rd(input reg_sel_t sel, input logic [127:0] exp, input logic err);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_sel <= sel;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
    check({rsp_valid, rsp_error}, {1'b1, err});
    check(rsp_data, exp);
  endtask
  // msb first over the 120 upper bits
  function automatic logic [6:0] crc7(input logic [119:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    end
    return c;
  endfunction
  task automatic t_busy();
    rd(SEL_OP_COND, 128'h40ff8080, 1'b0);
    check(rsp_data_b, 128'h00ff8000);
    rd(SEL_IDENTITY, 128'h0, 1'b1);
    rd(reg_sel_t'(2'h2), 128'h0, 1'b1);
    rd(reg_sel_t'(2'h3), 128'h0, 1'b1);
    check(line_oe, 1'b1);
    check(line_o, 1'b0);
    check(bus_all_ready, 1'b0);
    $display("busy test done");
  endtask
  task automatic t_ident();
    for (int i = 0; i < 200 && id_ready !== 1'b1; i++) @(posedge ref_clk);
    #1;
    check(id_ready, 1'b1);
    rd(SEL_IDENTITY, {id_hi, crc7(id_hi), 1'b1}, 1'b0);
    rd(SEL_OP_COND, 128'h40ff8080, 1'b0);
    $display("identity test done");
  endtask
  task automatic t_ready();
    @(posedge ref_clk);
    power_up_done <= 1'b1;
    other_busy <= 1'b1;
    repeat (3) @(posedge ref_clk);
    power_up_done <= 1'b0;
    #1;
    check(line_oe, 1'b0);
    check(bus_all_ready, 1'b0);
    rd(SEL_OP_COND, 128'hc0ff8080, 1'b0);
    check(rsp_data_b, 128'h80ff8000);
    @(posedge ref_clk);
    other_busy <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check(bus_all_ready, 1'b1);
    $display("ready test done");
  endtask
  task automatic t_rereset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(SEL_OP_COND, 128'h40ff8080, 1'b0);
    check(rsp_data_b, 128'h00ff8000);
    check(line_oe, 1'b1);
    $display("second reset test done");
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard, run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    id_hi = {8'h5a, 6'h00, 2'b01, 8'h3c, 48'h414243444546, 8'h10, 32'h1, 8'h10};
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_busy();
    t_ident();
    t_ready();
    t_rereset();
    close_out();
  end
endmodule
`default_nettype wire
